// [shared/dfm_pkg.sv]
// Constants and carrier types for the contact input / relay output mapper.
// Assumes one 25 MHz clock and an AXI4-Lite register bus with 32-bit data.
package dfm_pkg;

  // ==========================================================
  // Bus and register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_IN5_SEL = 8'h00;
  localparam logic [7:0] OFF_IN6_SEL = 8'h04;
  localparam logic [7:0] OFF_OUT1_SEL = 8'h08;
  localparam logic [7:0] OFF_THRESHOLD = 8'h0C;
  localparam logic [7:0] OFF_NET_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Reset values and ranges
  localparam logic [4:0] IN5_SEL_RESET = 5'h00;
  localparam logic [4:0] IN6_SEL_RESET = 5'h00;
  localparam logic [3:0] OUT1_SEL_RESET = 4'h1;
  localparam logic [4:0] IN_SEL_MAX = 5'h10;
  localparam logic [3:0] OUT_SEL_MAX = 4'hE;
  // Threshold in tenths of a percent: 10.0 % to 500.0 %
  localparam logic [12:0] THR_RESET = 13'h03E8;
  localparam logic [12:0] THR_MIN = 13'h0064;
  localparam logic [12:0] THR_MAX = 13'h1388;
  localparam logic [12:0] HYST_DIV = 13'h000A;

  // ==========================================================
  // Input function codes
  localparam logic [4:0] IN_NOT_USED = 5'h00;
  localparam logic [4:0] IN_RUN_STOP = 5'h01;
  localparam logic [4:0] IN_START_3W = 5'h02;
  localparam logic [4:0] IN_STOP_3W = 5'h03;
  localparam logic [4:0] IN_ENABLE = 5'h04;
  localparam logic [4:0] IN_LOCAL_REMOTE_SELECT = 5'h05;
  localparam logic [4:0] IN_JOG = 5'h06;
  localparam logic [4:0] IN_DIRECTION = 5'h07;
  localparam logic [4:0] IN_EXT_FAULT = 5'h08;
  localparam logic [4:0] IN_EXT_ALARM = 5'h09;
  localparam logic [4:0] IN_BRAKE = 5'h0A;
  localparam logic [4:0] IN_RESET = 5'h0B;
  localparam logic [4:0] IN_LOAD_USER = 5'h0C;
  localparam logic [4:0] IN_THERM_ALARM = 5'h0F;
  localparam logic [4:0] IN_THERM_FAULT = 5'h10;

  // ==========================================================
  // Output function codes
  localparam logic [3:0] OUT_NOT_USED = 4'h0;
  localparam logic [3:0] OUT_RUNNING = 4'h1;
  localparam logic [3:0] OUT_FULL_VOLT = 4'h2;
  localparam logic [3:0] OUT_BYPASS = 4'h3;
  localparam logic [3:0] OUT_FORWARD = 4'h4;
  localparam logic [3:0] OUT_DC_BRAKE = 4'h5;
  localparam logic [3:0] OUT_NO_FAULT = 4'h6;
  localparam logic [3:0] OUT_FAULT = 4'h7;
  localparam logic [3:0] OUT_NO_ALARM = 4'h8;
  localparam logic [3:0] OUT_ALARM = 4'h9;
  localparam logic [3:0] OUT_HEALTHY = 4'hA;
  localparam logic [3:0] OUT_PROGRAM = 4'hB;
  localparam logic [3:0] OUT_NETWORK = 4'hC;
  localparam logic [3:0] OUT_CURRENT = 4'hD;
  localparam logic [3:0] OUT_BREAKER = 4'hE;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic running;
    logic full_voltage;
    logic bypass_on;
    logic reverse_dir;
    logic dc_braking;
    logic fault_active;
    logic alarm_active;
    logic program_bit;
    logic decel_active;
    logic motor_started;
    logic [6:0] short_circuit;
    logic [15:0] current_pct;
  } dfm_starter_t;

  typedef struct packed {
    logic run_level;
    logic start_pulse;
    logic stop_pulse;
    logic general_enable;
    logic remote_select;
    logic jog_request;
    logic forward_contactor;
    logic reverse_contactor;
    logic external_fault;
    logic external_alarm;
    logic brake_request;
    logic fault_reset;
    logic load_user_one;
    logic load_user_two;
    logic thermistor_alarm;
    logic thermistor_fault;
  } dfm_cmd_t;

endpackage

// [logic/dfm_mapper.sv]
// Contact input function mapper and relay output selector with an
// AXI4-Lite register slave. Assumes contacts and starter state are
// synchronous to aclk; a contact reads 1 when closed.
//
// Overview of operation
// - Input five selector 0..16, default 0, stopped only
// - Code 1: closed runs, open stops
// - Code 4: global enable asserted only while every code 4 contact is closed
// - Code 5: open local, closed remote
// - Code 7: open forward, closed reverse contactor
// - Codes 8/9: open raises external fault/alarm
// - Code 10: closed requests braking
// - Code 11: closing edge clears active fault
// - Code 12: close loads set one, open two
// - Input six only: 15 alarm, 16 fault
// - Relay follows selected condition; selector 0..14, default 1
// - Code 0 keeps relay de-energized
// - Code 1 relay follows running incl. deceleration
// - Code 2 relay on at full voltage
// - Code 3 relay on with bypass engaged
// - Code 4 relay on running forward only
// - Code 5 relay on during DC braking
// - Codes 6..10 follow fault and alarm
// - Codes 11/12 follow program or network bit
// - Code 13 current compare with ten percent hysteresis
// - Code 14 relay on any short-circuit fault
`timescale 1ns/10ps
`default_nettype none

module dfm_mapper (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dfm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dfm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic contact_input_five,
  input wire logic contact_input_six,
  input wire dfm_pkg::dfm_starter_t starter,
  output dfm_pkg::dfm_cmd_t cmd,
  output logic relay_output_one
);
  import dfm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [4:0] input5_function_select;
    logic [4:0] input6_function_select;
    logic [3:0] output1_function_select;
    logic [12:0] current_compare_threshold;
    logic network_output_control_word;
    logic [1:0] prev_contact;
    logic prev_valid;
    logic cmp_on;
    logic relay;
    dfm_cmd_t cmd;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dfm_state_t;

  dfm_state_t st;
  dfm_state_t next_st;

  logic [1:0] contact;
  logic [4:0] sel [2];
  logic [12:0] hyst_low;
  logic [15:0] cur_tenths;
  logic cmp_window;
  logic relay_cond;

  assign contact = {contact_input_six, contact_input_five};
  assign sel[0] = st.input5_function_select;
  assign sel[1] = st.input6_function_select;
  assign hyst_low = st.current_compare_threshold
                    - (st.current_compare_threshold / HYST_DIV);
  assign cur_tenths = starter.current_pct;
  assign cmp_window = starter.full_voltage && starter.motor_started
                      && !starter.decel_active;

  // ==========================================================
  // Relay condition for the selected output function
  always_comb begin
    case (st.output1_function_select)
      OUT_NOT_USED: relay_cond = 1'b0;
      OUT_RUNNING: relay_cond = starter.running;
      OUT_FULL_VOLT: relay_cond = starter.full_voltage;
      OUT_BYPASS: relay_cond = starter.bypass_on;
      OUT_FORWARD: begin
        relay_cond = starter.running && !starter.reverse_dir;
      end
      OUT_DC_BRAKE: relay_cond = starter.dc_braking;
      OUT_NO_FAULT: relay_cond = !starter.fault_active;
      OUT_FAULT: relay_cond = starter.fault_active;
      OUT_NO_ALARM: relay_cond = !starter.alarm_active;
      OUT_ALARM: relay_cond = starter.alarm_active;
      OUT_HEALTHY: begin
        relay_cond = !starter.fault_active
                     && !starter.alarm_active;
      end
      OUT_PROGRAM: relay_cond = starter.program_bit;
      OUT_NETWORK: relay_cond = st.network_output_control_word;
      OUT_CURRENT: relay_cond = st.cmp_on;
      OUT_BREAKER: relay_cond = |starter.short_circuit;
      default: relay_cond = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic wr_go;
    logic stopped;
    logic closing;
    logic opening;
    logic any_enable_sel;
    logic all_enable_closed;
    wa = '0;
    wd = '0;
    wr_go = 1'b0;
    stopped = !starter.running;
    closing = 1'b0;
    opening = 1'b0;
    any_enable_sel = 1'b0;
    all_enable_closed = 1'b1;
    next_st = st;

    // Contact decode, two inputs combined
    next_st.cmd = '0;
    for (int i = 0; i < 2; i++) begin
      closing = st.prev_valid && contact[i] && !st.prev_contact[i];
      opening = st.prev_valid && !contact[i] && st.prev_contact[i];
      case (sel[i])
        IN_RUN_STOP: begin
          next_st.cmd.run_level = next_st.cmd.run_level
                                  | contact[i];
        end
        IN_START_3W: begin
          next_st.cmd.start_pulse = next_st.cmd.start_pulse
                                    | closing;
        end
        IN_STOP_3W: begin
          next_st.cmd.stop_pulse = next_st.cmd.stop_pulse
                                   | opening;
        end
        IN_ENABLE: begin
          any_enable_sel = 1'b1;
          all_enable_closed = all_enable_closed & contact[i];
        end
        IN_LOCAL_REMOTE_SELECT: begin
          next_st.cmd.remote_select = next_st.cmd.remote_select
                                      | contact[i];
        end
        IN_JOG: begin
          next_st.cmd.jog_request = next_st.cmd.jog_request
                                    | contact[i];
        end
        IN_DIRECTION: begin
          next_st.cmd.reverse_contactor = next_st.cmd.reverse_contactor
                                          | contact[i];
        end
        IN_EXT_FAULT: begin
          next_st.cmd.external_fault = next_st.cmd.external_fault
                                       | !contact[i];
        end
        IN_EXT_ALARM: begin
          next_st.cmd.external_alarm = next_st.cmd.external_alarm
                                       | !contact[i];
        end
        IN_BRAKE: begin
          next_st.cmd.brake_request = next_st.cmd.brake_request
                                      | contact[i];
        end
        IN_RESET: begin
          next_st.cmd.fault_reset = next_st.cmd.fault_reset
                                    | (closing
                                       && starter.fault_active);
        end
        IN_LOAD_USER: begin
          next_st.cmd.load_user_one = next_st.cmd.load_user_one
                                      | closing;
          next_st.cmd.load_user_two = next_st.cmd.load_user_two
                                      | opening;
        end
        IN_THERM_ALARM: begin
          if (i == 1) begin
            next_st.cmd.thermistor_alarm = !contact[i];
          end
        end
        IN_THERM_FAULT: begin
          if (i == 1) begin
            next_st.cmd.thermistor_fault = !contact[i];
          end
        end
        // Code 0 and reserved codes only show in the status register
        default: begin
        end
      endcase
    end
    next_st.cmd.general_enable = !any_enable_sel
                                 || all_enable_closed;
    next_st.cmd.forward_contactor = !next_st.cmd.reverse_contactor;
    next_st.prev_contact = contact;
    next_st.prev_valid = 1'b1;

    // Current compare with hysteresis on release
    if (!cmp_window) begin
      next_st.cmp_on = 1'b0;
    end else if (cur_tenths > {3'h0, st.current_compare_threshold}) begin
      next_st.cmp_on = 1'b1;
    end else if (cur_tenths <= {3'h0, hyst_low}) begin
      next_st.cmp_on = 1'b0;
    end
    next_st.relay = relay_cond;

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wr_go = 1'b1;
      wa = {st.aw_addr[ADDR_W-1:2], 2'h0};
      wd = st.w_data;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      case (wa)
        OFF_IN5_SEL: begin
          if (stopped && st.w_strb[0] && wd[4:0] <= IN_SEL_MAX) begin
            next_st.input5_function_select = wd[4:0];
          end else begin
            next_st.bresp = RESP_SLVERR;
          end
        end
        OFF_IN6_SEL: begin
          if (stopped && st.w_strb[0] && wd[4:0] <= IN_SEL_MAX) begin
            next_st.input6_function_select = wd[4:0];
          end else begin
            next_st.bresp = RESP_SLVERR;
          end
        end
        OFF_OUT1_SEL: begin
          if (stopped && st.w_strb[0] && wd[3:0] <= OUT_SEL_MAX
              && wd[4] == 1'b0) begin
            next_st.output1_function_select = wd[3:0];
          end else begin
            next_st.bresp = RESP_SLVERR;
          end
        end
        OFF_THRESHOLD: begin
          if (stopped && &st.w_strb[1:0] && wd[15:13] == 3'h0
              && wd[12:0] >= THR_MIN && wd[12:0] <= THR_MAX) begin
            next_st.current_compare_threshold = wd[12:0];
          end else begin
            next_st.bresp = RESP_SLVERR;
          end
        end
        OFF_NET_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.network_output_control_word = wd[0];
          end
        end
        OFF_STATUS: begin
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // AXI4-Lite read
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = '0;
      case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
        OFF_IN5_SEL: next_st.rdata[4:0] = st.input5_function_select;
        OFF_IN6_SEL: next_st.rdata[4:0] = st.input6_function_select;
        OFF_OUT1_SEL: next_st.rdata[3:0] = st.output1_function_select;
        OFF_THRESHOLD: next_st.rdata[12:0] = st.current_compare_threshold;
        OFF_NET_CTRL: next_st.rdata[0] = st.network_output_control_word;
        OFF_STATUS: begin
          next_st.rdata[1:0] = st.prev_contact;
          next_st.rdata[2] = st.relay;
          next_st.rdata[3] = st.cmp_on;
          next_st.rdata[31:16] = st.cmd;
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.input5_function_select <= IN5_SEL_RESET;
      st.input6_function_select <= IN6_SEL_RESET;
      st.output1_function_select <= OUT1_SEL_RESET;
      st.current_compare_threshold <= THR_RESET;
      st.cmd.general_enable <= 1'b1;
      st.cmd.forward_contactor <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cmd = st.cmd;
  assign relay_output_one = st.relay;

endmodule

`default_nettype wire

// [bench/dfm_field.sv]
// Field side model: contacts that settle one clock after a change of
// the wanted state, and a relay coil that follows the relay output.
`timescale 1ns/10ps
`default_nettype none
module dfm_field (
  input wire logic aclk,
  input wire logic [1:0] want,
  input wire logic relay_output_one,
  output logic contact_input_five,
  output logic contact_input_six,
  output logic coil_on
);
  initial {contact_input_six, contact_input_five} = 2'b00;
  // Contacts settle into place one clock late
  always @(posedge aclk) {contact_input_six, contact_input_five} <= want;
  assign coil_on = relay_output_one;
endmodule
`default_nettype wire

// [bench/dfm_mapper_asserts.sv]
// Concurrent checks on the ports of the mapper.
// Assumes the top dfm_mapper; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module dfm_mapper_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic contact_input_five,
  input wire logic contact_input_six,
  input wire dfm_pkg::dfm_starter_t starter,
  input wire dfm_pkg::dfm_cmd_t cmd,
  input wire logic relay_output_one
);
  import dfm_pkg::*;
  logic [1:0] prv;
  logic [1:0] rise;
  logic [1:0] fall;
  always_ff @(posedge aclk) begin
    prv <= {contact_input_six, contact_input_five};
    rise <= {contact_input_six, contact_input_five} & ~prv;
    fall <= ~{contact_input_six, contact_input_five} & prv;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Assertions
  a_dir_excl:
    assert property (!(cmd.forward_contactor && cmd.reverse_contactor))
    else $error("both contactors on");
  a_rev_cause:
    assert property (cmd.reverse_contactor |->
      $past(contact_input_five || contact_input_six))
    else $error("reverse without closed contact");
  a_start_cause:
    assert property (cmd.start_pulse |-> |rise)
    else $error("start without closing edge");
  a_stop_cause:
    assert property (cmd.stop_pulse |-> |fall)
    else $error("stop without opening edge");
  a_load_one:
    assert property (cmd.load_user_one |-> |rise)
    else $error("set one without closing edge");
  a_load_two:
    assert property (cmd.load_user_two |-> |fall)
    else $error("set two without opening edge");
  a_reset_cause:
    assert property (cmd.fault_reset |-> |rise && $past(starter.fault_active))
    else $error("fault reset without cause");
  a_therm_fault:
    assert property (cmd.thermistor_fault |-> !$past(contact_input_six))
    else $error("thermistor fault with closed contact");
  a_therm_alarm:
    assert property (cmd.thermistor_alarm |-> !$past(contact_input_six))
    else $error("thermistor alarm with closed contact");
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_start: cover property (cmd.start_pulse);
  c_reset: cover property (cmd.fault_reset);
  c_relay: cover property (relay_output_one);
endmodule
bind dfm_mapper dfm_mapper_chk i_chk (.*);
`default_nettype wire

// [bench/digital_io_function_mapper_tb.sv]
// Self-checking bench for the mapper: register bus, contact codes,
// relay codes and current compare.
// Assumes dfm_pkg, dfm_mapper, dfm_field and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module digital_io_function_mapper_tb;
  import dfm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic contact_input_five, contact_input_six, relay_output_one;
  dfm_starter_t starter = '0;
  dfm_cmd_t cmd;
  logic [1:0] want = 2'b00;
  logic probe = 1'b0;
  logic [31:0] q[$];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 88;

  dfm_mapper i_dut (.*);
  dfm_field i_field (.*, .coil_on());
  always #20 aclk = ~aclk;

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(negedge aclk) begin
    if ((s_axi_bvalid & s_axi_bready) === 1'b1)
      chk({30'h0, s_axi_bresp}, q.pop_front());
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
      chk({30'h0, s_axi_rresp}, q.pop_front());
      chk(s_axi_rdata, q.pop_front());
    end
    if (probe) chk({15'h0, cmd, relay_output_one}, q.pop_front());
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================
  // Bus and probe drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    logic got;
    got = 1'b0;
    q.push_back({30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    logic got;
    got = 1'b0;
    q.push_back({30'h0, r});
    q.push_back(d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      got = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pr(input logic [31:0] e);
    q.push_back(e);
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
    @(posedge aclk);
  endtask

  // ==========================================================
  // Expected commands and relay
  function automatic dfm_cmd_t ec(input int c, input logic k,
      input int e, input bit six);
    dfm_cmd_t x;
    x = '0;
    x.general_enable = 1'b1;
    x.forward_contactor = 1'b1;
    case (c)
      1: x.run_level = k;
      2: x.start_pulse = (e == 1);
      3: x.stop_pulse = (e == 2);
      4: x.general_enable = k;
      5: x.remote_select = k;
      6: x.jog_request = k;
      7: begin
        x.forward_contactor = !k;
        x.reverse_contactor = k;
      end
      8: x.external_fault = !k;
      9: x.external_alarm = !k;
      10: x.brake_request = k;
      11: x.fault_reset = (e == 1);
      12: begin
        x.load_user_one = (e == 1);
        x.load_user_two = (e == 2);
      end
      15: x.thermistor_alarm = six && !k;
      16: x.thermistor_fault = six && !k;
      default: x = x;
    endcase
    return x;
  endfunction

  function automatic logic rel(input int c, input dfm_starter_t t,
      input logic n);
    case (c)
      1: return t.running;
      2: return t.full_voltage;
      3: return t.bypass_on;
      4: return t.running && !t.reverse_dir;
      5: return t.dc_braking;
      6: return !t.fault_active;
      7: return t.fault_active;
      8: return !t.alarm_active;
      9: return t.alarm_active;
      10: return !(t.fault_active || t.alarm_active);
      11: return t.program_bit;
      12: return n;
      14: return |t.short_circuit;
      default: return 1'b0;
    endcase
  endfunction

  // Open, close, open one contact under one input code
  task automatic sc(input bit six, input int c);
    wr(six ? OFF_IN6_SEL : OFF_IN5_SEL, 32'(c), RESP_OKAY);
    repeat (2) @(posedge aclk);
    pr({15'h0, ec(c, 1'b0, 0, six), 1'b0});
    want <= six ? 2'b10 : 2'b01;
    repeat (2) @(posedge aclk);
    pr({15'h0, ec(c, 1'b1, 1, six), 1'b0});
    want <= 2'b00;
    repeat (2) @(posedge aclk);
    pr({15'h0, ec(c, 1'b0, 2, six), 1'b0});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [63:0] r;
    dfm_starter_t st;
    logic nb;
    int cur [5];
    logic [4:0] on;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_IN5_SEL, 32'h0, RESP_OKAY);
    rd(OFF_IN6_SEL, 32'h0, RESP_OKAY);
    rd(OFF_OUT1_SEL, 32'h1, RESP_OKAY);
    rd(OFF_THRESHOLD, 32'h3E8, RESP_OKAY);
    want <= 2'b11;
    repeat (3) @(posedge aclk);
    rd(OFF_STATUS, {ec(0, 1'b0, 0, 1'b0), 16'h0003}, RESP_OKAY);
    want <= 2'b00;
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    wr(OFF_THRESHOLD, 32'h63, RESP_SLVERR);
    wr(OFF_IN5_SEL, 32'h11, RESP_SLVERR);
    wr(OFF_OUT1_SEL, 32'hF, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    starter.running <= 1'b1;
    wr(OFF_IN5_SEL, 32'h1, RESP_SLVERR);
    rd(OFF_IN5_SEL, 32'h0, RESP_OKAY);
    st = '0;
    st.fault_active = 1'b1;
    starter <= st;
    for (int i = 0; i < 17; i++) sc(1'b0, i);
    wr(OFF_IN5_SEL, 32'h0, RESP_OKAY);
    for (int i = 13; i < 17; i++) sc(1'b1, i);
    wr(OFF_IN6_SEL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      starter <= '0;
      @(posedge aclk);
      wr(OFF_OUT1_SEL, 32'(i), RESP_OKAY);
      repeat (4) begin
        r = {$random(seed), $random(seed)};
        st = dfm_starter_t'(r[32:0]);
        if (i == 13) st.full_voltage = 1'b0;
        nb = r[40];
        wr(OFF_NET_CTRL, {31'h0, nb}, RESP_OKAY);
        starter <= st;
        repeat (2) @(posedge aclk);
        pr({15'h0, ec(0, 1'b0, 0, 1'b0), rel(i, st, nb)});
      end
    end
    st = '0;
    st.full_voltage = 1'b1;
    st.motor_started = 1'b1;
    starter <= st;
    wr(OFF_THRESHOLD, 32'h3E8, RESP_OKAY);
    wr(OFF_OUT1_SEL, 32'hD, RESP_OKAY);
    cur = '{1000, 1001, 901, 900, 1001};
    on = 5'b10110;
    for (int i = 0; i < 5; i++) begin
      st.current_pct = 16'(cur[i]);
      starter <= st;
      repeat (2) @(posedge aclk);
      pr({15'h0, ec(0, 1'b0, 0, 1'b0), on[i]});
    end
    st.decel_active = 1'b1;
    starter <= st;
    repeat (2) @(posedge aclk);
    pr({15'h0, ec(0, 1'b0, 0, 1'b0), 1'b0});
    end_of_test();
  end
endmodule
`default_nettype wire
